// File: design/reader_regs_pkg.sv
package reader_regs_pkg;

	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	localparam int NUM_REGS = 32;

	// Register addresses.
	localparam logic [4:0] ADDR_CHIP_STATE_CONTROL      = 5'h00;
	localparam logic [4:0] ADDR_PROTOCOL_SELECT_CONTROL = 5'h01;
	localparam logic [4:0] ADDR_TYPE_B_TRANSMIT_OPTIONS = 5'h02;
	localparam logic [4:0] ADDR_TYPE_A_FAST_RATE_OPTS   = 5'h03;
	localparam logic [4:0] ADDR_TRANSMIT_TIMER_HIGH     = 5'h04;
	localparam logic [4:0] ADDR_TRANSMIT_TIMER_LOW      = 5'h05;
	localparam logic [4:0] ADDR_TRANSMIT_PULSE_LENGTH   = 5'h06;
	localparam logic [4:0] ADDR_RECEIVE_NO_REPLY        = 5'h07;
	localparam logic [4:0] ADDR_RECEIVE_WAIT_TIME       = 5'h08;
	localparam logic [4:0] ADDR_MODULATOR_CLOCK_OUT     = 5'h09;
	localparam logic [4:0] ADDR_RECEIVE_SPECIAL         = 5'h0A;
	localparam logic [4:0] ADDR_REGULATOR_IO_CONTROL    = 5'h0B;
	localparam logic [4:0] ADDR_INTERRUPT_STATUS        = 5'h0C;
	localparam logic [4:0] ADDR_COLLISION_POS_IRQ_MASK  = 5'h0D;
	localparam logic [4:0] ADDR_COLLISION_POSITION      = 5'h0E;
	localparam logic [4:0] ADDR_SIGNAL_LEVEL_OSC        = 5'h0F;
	localparam logic [4:0] ADDR_SPECIAL_FUNCTION_A      = 5'h10;
	localparam logic [4:0] ADDR_SPECIAL_FUNCTION_B      = 5'h11;
	localparam logic [4:0] ADDR_FIFO_IRQ_THRESHOLDS     = 5'h14;
	localparam logic [4:0] ADDR_TEST_A                  = 5'h1A;
	localparam logic [4:0] ADDR_TEST_B                  = 5'h1B;
	localparam logic [4:0] ADDR_FIFO_STATE              = 5'h1C;
	localparam logic [4:0] ADDR_TRANSMIT_LENGTH_FIRST   = 5'h1D;
	localparam logic [4:0] ADDR_TRANSMIT_LENGTH_SECOND  = 5'h1E;
	localparam logic [4:0] ADDR_FIFO_DATA_PORT          = 5'h1F;

	// Preset values.
	localparam logic [7:0] RST_CHIP_STATE_CONTROL      = 8'h01;
	localparam logic [7:0] RST_PROTOCOL_SELECT_CONTROL = 8'h02;
	localparam logic [7:0] RST_TRANSMIT_TIMER          = 8'hC1;
	localparam logic [7:0] RST_RECEIVE_NO_REPLY        = 8'h0E;
	localparam logic [7:0] RST_RECEIVE_WAIT_TIME       = 8'h07;
	localparam logic [7:0] RST_MODULATOR_CLOCK_OUT     = 8'h91;
	localparam logic [7:0] RST_RECEIVE_SPECIAL         = 8'h10;
	localparam logic [7:0] RST_REGULATOR_IO_CONTROL    = 8'h87;
	localparam logic [7:0] RST_COLLISION_POS_IRQ_MASK  = 8'h3E;
	localparam logic [7:0] RST_ZERO                    = 8'h00;

	// Chip state control field positions.
	localparam int BIT_STANDBY          = 7;
	localparam int BIT_BYPASS_FRAMING   = 6;
	localparam int BIT_CARRIER_ENABLE   = 5;
	localparam int BIT_POWER_HALVE      = 4;
	localparam int BIT_AUX_INPUT_SELECT = 3;
	localparam int BIT_RESERVED         = 2;
	localparam int BIT_FORCE_RECEIVER   = 1;
	localparam int BIT_SUPPLY_RANGE     = 0;
	localparam logic [7:0] CHIP_STATE_WRITE_MASK = 8'hFB;

	// Protocol select control fields.
	localparam int BIT_DIRECT_MODE_TYPE = 6;
	localparam int PROTOCOL_CODE_W      = 5;

	// Wake-up time from standby.
	localparam int CLK_PERIOD_NS = 100;
	localparam int WAKE_TIME_NS  = 100000;
	localparam int WAKE_CYCLES   = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		power_active,
		power_standby,
		power_waking
	} power_state_e;

endpackage

// File: design/reader_register_map_chip_control.sv
`timescale 1ns/1ns
`default_nettype none

module reader_register_map_chip_control #(
	parameter int WAKE_COUNT = reader_regs_pkg::WAKE_CYCLES
) (
	// Clock and reset.
	input  wire logic                               ref_clk,
	input  wire logic                               rst_b,
	input  wire logic                               chip_enable,
	// Host register port.
	input  wire logic [reader_regs_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic                               reg_write,
	input  wire logic                               reg_read,
	input  wire logic [reader_regs_pkg::DATA_W-1:0] reg_wdata,
	output logic      [reader_regs_pkg::DATA_W-1:0] reg_rdata,
	output logic                                    reg_rvalid,
	// Status from the reader core.
	input  wire logic [reader_regs_pkg::DATA_W-1:0] irq_status_in,
	input  wire logic [reader_regs_pkg::DATA_W-1:0] collision_pos_in,
	input  wire logic [reader_regs_pkg::DATA_W-1:0] signal_level_in,
	input  wire logic [reader_regs_pkg::DATA_W-1:0] fifo_state_in,
	input  wire logic [reader_regs_pkg::DATA_W-1:0] fifo_rdata_in,
	// FIFO data port strobes.
	output logic                                    fifo_write,
	output logic                                    fifo_read,
	output logic      [reader_regs_pkg::DATA_W-1:0] fifo_wdata,
	// Receive inputs.
	input  wire logic                               main_receive_input,
	input  wire logic                               aux_receive_input,
	output logic                                    selected_receive_input,
	// Chip control outputs.
	output logic                                    standby,
	output logic                                    regulators_on,
	output logic                                    oscillator_on,
	output logic                                    full_operation,
	output logic                                    framing_enable,
	output logic                                    direct_mode_0,
	output logic                                    direct_mode_1,
	output logic                                    transmitter_enable,
	output logic                                    receiver_enable,
	output logic                                    tx_oscillator_enable,
	output logic                                    output_power_halve,
	output logic                                    supply_range_select,
	output logic      [reader_regs_pkg::PROTOCOL_CODE_W-1:0] protocol_code
);
	import reader_regs_pkg::*;

	// Counter sized from the parameter so a long wake-up time cannot wrap it.
	localparam int WAKE_W = (WAKE_COUNT > 1) ? $clog2(WAKE_COUNT) : 1;

	typedef struct packed {
		logic [NUM_REGS-1:0][DATA_W-1:0] regs;
		power_state_e                    power;
		logic [WAKE_W-1:0]               wake_count;
		logic [DATA_W-1:0]               rdata;
		logic                            rvalid;
		logic                            fifo_write;
		logic                            fifo_read;
		logic [DATA_W-1:0]               fifo_wdata;
		logic                            rx_sel;
		logic                            standby;
		logic                            full_op;
		logic                            framing;
		logic                            direct_0;
		logic                            direct_1;
		logic                            tx_en;
		logic                            rx_en;
		logic                            tx_osc;
		logic                            half_power;
		logic                            supply_range;
		logic [PROTOCOL_CODE_W-1:0]      protocol;
	} state_s;

	state_s state;
	state_s next_state;

	// Preset value of each address; read-only and unlisted slots hold zero.
	function automatic logic [DATA_W-1:0] preset_of(input logic [ADDR_W-1:0] a);
		case (a)
			ADDR_CHIP_STATE_CONTROL:      preset_of = RST_CHIP_STATE_CONTROL;
			ADDR_PROTOCOL_SELECT_CONTROL: preset_of = RST_PROTOCOL_SELECT_CONTROL;
			ADDR_TRANSMIT_TIMER_HIGH:     preset_of = RST_TRANSMIT_TIMER;
			ADDR_TRANSMIT_TIMER_LOW:      preset_of = RST_TRANSMIT_TIMER;
			ADDR_RECEIVE_NO_REPLY:        preset_of = RST_RECEIVE_NO_REPLY;
			ADDR_RECEIVE_WAIT_TIME:       preset_of = RST_RECEIVE_WAIT_TIME;
			ADDR_MODULATOR_CLOCK_OUT:     preset_of = RST_MODULATOR_CLOCK_OUT;
			ADDR_RECEIVE_SPECIAL:         preset_of = RST_RECEIVE_SPECIAL;
			ADDR_REGULATOR_IO_CONTROL:    preset_of = RST_REGULATOR_IO_CONTROL;
			ADDR_COLLISION_POS_IRQ_MASK:  preset_of = RST_COLLISION_POS_IRQ_MASK;
			default:                      preset_of = RST_ZERO;
		endcase
	endfunction

	// Addresses whose contents are stored here and written by the host.
	function automatic logic is_stored(input logic [ADDR_W-1:0] a);
		case (a)
			ADDR_CHIP_STATE_CONTROL, ADDR_PROTOCOL_SELECT_CONTROL,
			ADDR_TYPE_B_TRANSMIT_OPTIONS, ADDR_TYPE_A_FAST_RATE_OPTS,
			ADDR_TRANSMIT_TIMER_HIGH, ADDR_TRANSMIT_TIMER_LOW,
			ADDR_TRANSMIT_PULSE_LENGTH, ADDR_RECEIVE_NO_REPLY,
			ADDR_RECEIVE_WAIT_TIME, ADDR_MODULATOR_CLOCK_OUT,
			ADDR_RECEIVE_SPECIAL, ADDR_REGULATOR_IO_CONTROL,
			ADDR_COLLISION_POS_IRQ_MASK, ADDR_SPECIAL_FUNCTION_A,
			ADDR_SPECIAL_FUNCTION_B, ADDR_FIFO_IRQ_THRESHOLDS,
			ADDR_TEST_A, ADDR_TEST_B,
			ADDR_TRANSMIT_LENGTH_FIRST, ADDR_TRANSMIT_LENGTH_SECOND:
				is_stored = 1'b1;
			default:
				is_stored = 1'b0;
		endcase
	endfunction

	logic [DATA_W-1:0] chip_ctl;
	logic [DATA_W-1:0] proto_ctl;
	logic [DATA_W-1:0] read_value;
	logic              ready;

	always_comb begin
		next_state = state;
		next_state.fifo_write = 1'b0;
		next_state.fifo_read = 1'b0;
		next_state.rvalid = 1'b0;
		read_value = RST_ZERO;

		case (reg_addr)
			ADDR_INTERRUPT_STATUS:   read_value = irq_status_in;
			ADDR_COLLISION_POSITION: read_value = collision_pos_in;
			ADDR_SIGNAL_LEVEL_OSC:   read_value = signal_level_in;
			ADDR_FIFO_STATE:         read_value = fifo_state_in;
			ADDR_FIFO_DATA_PORT:     read_value = fifo_rdata_in;
			default: begin
				if (is_stored(reg_addr)) begin
					read_value = state.regs[reg_addr];
				end
			end
		endcase

		if (reg_read) begin
			next_state.rdata = read_value;
			next_state.rvalid = 1'b1;
			next_state.fifo_read = (reg_addr == ADDR_FIFO_DATA_PORT);
		end

		if (reg_write) begin
			if (reg_addr == ADDR_FIFO_DATA_PORT) begin
				next_state.fifo_write = 1'b1;
				next_state.fifo_wdata = reg_wdata;
			end else if (reg_addr == ADDR_CHIP_STATE_CONTROL) begin
				next_state.regs[reg_addr] = reg_wdata & CHIP_STATE_WRITE_MASK;
			end else if (is_stored(reg_addr)) begin
				next_state.regs[reg_addr] = reg_wdata;
			end
		end

		// preset while the activate pin is low
		if (!chip_enable) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				next_state.regs[i] = preset_of(ADDR_W'(i));
			end
		end

		chip_ctl = next_state.regs[ADDR_CHIP_STATE_CONTROL];
		proto_ctl = next_state.regs[ADDR_PROTOCOL_SELECT_CONTROL];

		case (state.power)
			power_active: begin
				if (chip_ctl[BIT_STANDBY]) begin
					next_state.power = power_standby;
				end
			end
			power_standby: begin
				if (!chip_ctl[BIT_STANDBY]) begin
					next_state.power = power_waking;
					next_state.wake_count = WAKE_W'(WAKE_COUNT - 1);
				end
			end
			power_waking: begin
				if (chip_ctl[BIT_STANDBY]) begin
					next_state.power = power_standby;
				end else if (state.wake_count == '0) begin
					next_state.power = power_active;
				end else begin
					next_state.wake_count = state.wake_count - WAKE_W'(1);
				end
			end
			default: begin
				next_state.power = power_active;
			end
		endcase
		ready = (next_state.power == power_active);

		next_state.standby = (next_state.power == power_standby);
		next_state.full_op = ready;

		next_state.framing = !chip_ctl[BIT_BYPASS_FRAMING];
		next_state.direct_0 = chip_ctl[BIT_BYPASS_FRAMING] && !proto_ctl[BIT_DIRECT_MODE_TYPE];
		next_state.direct_1 = chip_ctl[BIT_BYPASS_FRAMING] && proto_ctl[BIT_DIRECT_MODE_TYPE];

		next_state.tx_en = chip_ctl[BIT_CARRIER_ENABLE] && ready;
		next_state.rx_en = (chip_ctl[BIT_FORCE_RECEIVER] || chip_ctl[BIT_CARRIER_ENABLE]) && ready;
		next_state.tx_osc = (chip_ctl[BIT_FORCE_RECEIVER] || chip_ctl[BIT_CARRIER_ENABLE]) && ready;

		next_state.half_power = chip_ctl[BIT_POWER_HALVE];
		next_state.rx_sel = chip_ctl[BIT_AUX_INPUT_SELECT] ? aux_receive_input : main_receive_input;
		next_state.supply_range = chip_ctl[BIT_SUPPLY_RANGE];
		next_state.protocol = proto_ctl[PROTOCOL_CODE_W-1:0];
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				state.regs[i] <= preset_of(ADDR_W'(i));
			end
			state.power <= power_active;
			state.wake_count <= '0;
			state.rdata <= RST_ZERO;
			state.rvalid <= 1'b0;
			state.fifo_write <= 1'b0;
			state.fifo_read <= 1'b0;
			state.fifo_wdata <= RST_ZERO;
			state.rx_sel <= 1'b0;
			state.standby <= RST_CHIP_STATE_CONTROL[BIT_STANDBY];
			state.full_op <= !RST_CHIP_STATE_CONTROL[BIT_STANDBY];
			state.framing <= !RST_CHIP_STATE_CONTROL[BIT_BYPASS_FRAMING];
			state.direct_0 <= 1'b0;
			state.direct_1 <= 1'b0;
			state.tx_en <= RST_CHIP_STATE_CONTROL[BIT_CARRIER_ENABLE];
			state.rx_en <= 1'b0;
			state.tx_osc <= 1'b0;
			state.half_power <= RST_CHIP_STATE_CONTROL[BIT_POWER_HALVE];
			state.supply_range <= RST_CHIP_STATE_CONTROL[BIT_SUPPLY_RANGE];
			state.protocol <= RST_PROTOCOL_SELECT_CONTROL[PROTOCOL_CODE_W-1:0];
		end else begin
			state <= next_state;
		end
	end

	// Regulators and oscillator stay up in standby so wake-up needs no restart.
	assign regulators_on = 1'b1;
	assign oscillator_on = 1'b1;

	assign reg_rdata = state.rdata;
	assign reg_rvalid = state.rvalid;
	assign fifo_write = state.fifo_write;
	assign fifo_read = state.fifo_read;
	assign fifo_wdata = state.fifo_wdata;
	assign selected_receive_input = state.rx_sel;
	assign standby = state.standby;
	assign full_operation = state.full_op;
	assign framing_enable = state.framing;
	assign direct_mode_0 = state.direct_0;
	assign direct_mode_1 = state.direct_1;
	assign transmitter_enable = state.tx_en;
	assign receiver_enable = state.rx_en;
	assign tx_oscillator_enable = state.tx_osc;
	assign output_power_halve = state.half_power;
	assign supply_range_select = state.supply_range;
	assign protocol_code = state.protocol;

endmodule

`default_nettype wire

// File: testbench/reader_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module reader_host_model (
	// Clock and answer from the device.
	input  wire logic       ref_clk,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid,
	// Request to the device.
	output logic      [4:0] reg_addr,
	output logic            reg_write,
	output logic            reg_read,
	output logic      [7:0] reg_wdata
);
	initial begin
		reg_addr = 5'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_wdata = 8'h00;
	end
	// Released lines show the inverse so a stale value is never mistaken for a live one.
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'b1;
		@(posedge ref_clk);
		#1;
		reg_write = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic ok);
		@(posedge ref_clk);
		#1;
		reg_addr = a;
		reg_read = 1'b1;
		@(posedge ref_clk);
		#1;
		reg_read = 1'b0;
		reg_addr = ~a;
		ok = reg_rvalid;
		d = reg_rdata;
	endtask
	task automatic direct(input logic m);
		wr(5'h01, {1'b0, m, 6'h02});
		wr(5'h00, 8'h40);
	endtask
endmodule
`default_nettype wire

// File: testbench/reader_regs_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module reader_regs_monitor #(
	parameter int WAKE_COUNT = reader_regs_pkg::WAKE_CYCLES
) (
	// Clock, reset and host port.
	input wire logic       ref_clk,
	input wire logic       rst_b,
	input wire logic       chip_enable,
	input wire logic [4:0] reg_addr,
	input wire logic       reg_write,
	input wire logic       reg_read,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_rvalid,
	input wire logic [7:0] irq_status_in,
	// Receive path and chip control.
	input wire logic       aux_receive_input,
	input wire logic       selected_receive_input,
	input wire logic       standby,
	input wire logic       full_operation,
	input wire logic       framing_enable,
	input wire logic       direct_mode_0,
	input wire logic       direct_mode_1,
	input wire logic       transmitter_enable,
	input wire logic       receiver_enable,
	input wire logic       tx_oscillator_enable,
	input wire logic       output_power_halve
);
	logic        ctl_wr;
	logic [15:0] wake_cnt;
	assign ctl_wr = reg_write && reg_addr == 5'h00 && chip_enable;
	// Counts only the waking span, so the figure is checked the moment operation resumes.
	always_ff @(posedge ref_clk) begin
		if (!rst_b || standby || full_operation) begin
			wake_cnt <= 16'h0000;
		end else begin
			wake_cnt <= wake_cnt + 16'h0001;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	property p_standby;
		ctl_wr && reg_wdata[7] |=> standby && !full_operation && !transmitter_enable;
	endproperty
	property p_wake;
		$rose(full_operation) && $past(chip_enable) && $past(chip_enable, 2) && !$past(standby)
			|-> wake_cnt == 16'(WAKE_COUNT);
	endproperty
	property p_direct;
		ctl_wr && reg_wdata[6] |=> !framing_enable && (direct_mode_0 ^ direct_mode_1);
	endproperty
	property p_frame;
		ctl_wr && !reg_wdata[6] |=> framing_enable && !direct_mode_0 && !direct_mode_1;
	endproperty
	property p_txon;
		ctl_wr && reg_wdata[5] && !reg_wdata[7] && full_operation |=> transmitter_enable;
	endproperty
	property p_halve;
		ctl_wr |=> output_power_halve == $past(reg_wdata[4]);
	endproperty
	property p_aux;
		ctl_wr && reg_wdata[3] ##1 (!reg_write && chip_enable)
			|=> selected_receive_input == $past(aux_receive_input);
	endproperty
	property p_force;
		ctl_wr && reg_wdata[1] && !reg_wdata[7] && full_operation
			|=> receiver_enable && tx_oscillator_enable;
	endproperty
	property p_auto;
		ctl_wr && !reg_wdata[1] && !reg_wdata[5] |=> !receiver_enable && !tx_oscillator_enable;
	endproperty
	property p_ro;
		reg_read && reg_addr == 5'h0C |=> reg_rvalid && reg_rdata == $past(irq_status_in);
	endproperty
	property p_unl;
		reg_read && reg_addr == 5'h12 |=> reg_rvalid && reg_rdata == 8'h00;
	endproperty
	a_standby: assert property (p_standby) else $error("standby entry wrong");
	a_wake: assert property (p_wake) else $error("wake time wrong");
	a_direct: assert property (p_direct) else $error("direct mode wrong");
	a_frame: assert property (p_frame) else $error("framing mode wrong");
	a_txon: assert property (p_txon) else $error("transmitter not on");
	a_halve: assert property (p_halve) else $error("power halve wrong");
	a_aux: assert property (p_aux) else $error("aux input not selected");
	a_force: assert property (p_force) else $error("forced receiver off");
	a_auto: assert property (p_auto) else $error("receiver on without cause");
	a_ro: assert property (p_ro) else $error("status read wrong");
	a_unl: assert property (p_unl) else $error("unlisted read not zero");
	c_standby: cover property (standby ##1 !standby);
	c_wake: cover property ($rose(full_operation));
	c_direct: cover property (direct_mode_1);
endmodule
bind reader_register_map_chip_control reader_regs_monitor #(.WAKE_COUNT(WAKE_COUNT))
	reader_regs_monitor_i (.ref_clk, .rst_b, .chip_enable, .reg_addr, .reg_write, .reg_read,
	.reg_wdata, .reg_rdata, .reg_rvalid, .irq_status_in, .aux_receive_input,
	.selected_receive_input, .standby, .full_operation, .framing_enable, .direct_mode_0,
	.direct_mode_1, .transmitter_enable, .receiver_enable, .tx_oscillator_enable,
	.output_power_halve);
`default_nettype wire

// File: testbench/reader_register_map_chip_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module reader_register_map_chip_control_tb;
	import reader_regs_pkg::*;
	localparam int WAKE = 4;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic chip_enable = 1'b1;
	logic main_receive_input = 1'b1;
	logic aux_receive_input = 1'b0;
	logic [7:0] irq_status_in = 8'h5A, collision_pos_in = 8'h3C, signal_level_in = 8'h40;
	logic [7:0] fifo_state_in = 8'h11, fifo_rdata_in = 8'h77;
	logic [4:0] reg_addr;
	logic reg_write, reg_read, reg_rvalid, fifo_write, fifo_read, selected_receive_input;
	logic [7:0] reg_wdata, reg_rdata, fifo_wdata, shadow [32];
	logic standby, regulators_on, oscillator_on, full_operation, framing_enable;
	logic direct_mode_0, direct_mode_1, transmitter_enable, receiver_enable;
	logic tx_oscillator_enable, output_power_halve, supply_range_select;
	logic [4:0] protocol_code;
	logic [7:0] tbl [7] = '{8'h20, 8'h34, 8'h38, 8'h02, 8'h00, 8'h13, 8'h2D};
	int mismatches = 0;
	int comparisons = 0;
	wire logic [7:0] ctl = {standby, full_operation, framing_enable, transmitter_enable,
		receiver_enable, tx_oscillator_enable, output_power_halve, supply_range_select};
	wire logic [7:0] mode = {direct_mode_0, direct_mode_1, regulators_on & oscillator_on,
		protocol_code};
	reader_register_map_chip_control #(.WAKE_COUNT(WAKE)) reader_register_map_chip_control_i (
		.ref_clk, .rst_b, .chip_enable, .reg_addr, .reg_write, .reg_read, .reg_wdata,
		.reg_rdata, .reg_rvalid, .irq_status_in, .collision_pos_in, .signal_level_in,
		.fifo_state_in, .fifo_rdata_in, .fifo_write, .fifo_read, .fifo_wdata,
		.main_receive_input, .aux_receive_input, .selected_receive_input, .standby,
		.regulators_on, .oscillator_on, .full_operation, .framing_enable, .direct_mode_0,
		.direct_mode_1, .transmitter_enable, .receiver_enable, .tx_oscillator_enable,
		.output_power_halve, .supply_range_select, .protocol_code);
	reader_host_model reader_host_model_i (.ref_clk, .reg_rdata, .reg_rvalid, .reg_addr,
		.reg_write, .reg_read, .reg_wdata);
	function automatic logic [7:0] preset(input logic [4:0] a);
		case (a)
			5'h00: preset = RST_CHIP_STATE_CONTROL;
			5'h01: preset = RST_PROTOCOL_SELECT_CONTROL;
			5'h04, 5'h05: preset = RST_TRANSMIT_TIMER;
			5'h07: preset = RST_RECEIVE_NO_REPLY;
			5'h08: preset = RST_RECEIVE_WAIT_TIME;
			5'h09: preset = RST_MODULATOR_CLOCK_OUT;
			5'h0A: preset = RST_RECEIVE_SPECIAL;
			5'h0B: preset = RST_REGULATOR_IO_CONTROL;
			5'h0D: preset = RST_COLLISION_POS_IRQ_MASK;
			default: preset = RST_ZERO;
		endcase
	endfunction
	function automatic logic [7:0] live(input logic [4:0] a);
		case (a)
			5'h0C: live = irq_status_in;
			5'h0E: live = collision_pos_in;
			5'h0F: live = signal_level_in;
			5'h1C: live = fifo_state_in;
			5'h1F: live = fifo_rdata_in;
			default: live = shadow[a];
		endcase
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Status and unlisted places keep their shadow untouched, so reads must ignore the write.
	task automatic put(input logic [4:0] a, input logic [7:0] d);
		reader_host_model_i.wr(a, d);
		if (!(a inside {5'h0C, 5'h0E, 5'h0F, 5'h12, 5'h13, [5'h15:5'h19], 5'h1C})) begin
			shadow[a] = (a == 5'h00) ? (d & CHIP_STATE_WRITE_MASK) : d;
		end
	endtask
	task automatic scan();
		logic [7:0] d;
		logic ok;
		for (int i = 0; i < 32; i++) begin
			reader_host_model_i.rd(5'(i), d, ok);
			chk({7'h00, ok}, 8'h01);
			chk(d, live(5'(i)));
			chk({7'h00, fifo_read}, {7'h00, i == 31});
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		forever #50 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (4000) @(posedge ref_clk);
		mismatches++;
		$display("watchdog expired");
		end_of_test();
	end
	initial begin
		logic [7:0] d;
		logic ok;
		repeat (2) @(posedge ref_clk);
		#1 rst_b = 1'b1;
		for (int i = 0; i < 32; i++) shadow[i] = preset(5'(i));
		scan();
		$display("test presets done");
		irq_status_in = 8'hA6;
		fifo_rdata_in = 8'h88;
		for (int i = 1; i < 31; i++) put(5'(i), 8'hA5 ^ 8'(i * 7));
		put(5'h1F, 8'h3C);
		chk({7'h00, fifo_write}, 8'h01);
		chk(fifo_wdata, 8'h3C);
		scan();
		$display("test access kinds done");
		foreach (tbl[i]) begin
			// Opposite levels on the two inputs show which one is routed.
			main_receive_input = tbl[i][0];
			aux_receive_input = !tbl[i][0];
			put(5'h00, tbl[i]);
			chk(ctl, {3'b011, {3{tbl[i][5]}} | {1'b0, {2{tbl[i][1]}}}, tbl[i][4], tbl[i][0]});
			@(posedge ref_clk);
			#1;
			chk({7'h00, selected_receive_input}, {7'h00, tbl[i][3] ^ tbl[i][0]});
			reader_host_model_i.rd(5'h00, d, ok);
			chk(d, tbl[i] & 8'hFB);
		end
		for (int m = 0; m < 2; m++) begin
			reader_host_model_i.direct(m[0]);
			chk(mode, {!m[0], m[0], 1'b1, 5'h02});
			chk(ctl, 8'h40);
		end
		put(5'h00, 8'h20);
		chk(ctl, 8'h7C);
		$display("test chip control done");
		put(5'h00, 8'hA0);
		chk(ctl, 8'hA0);
		chk(mode, {2'b00, 1'b1, 5'h02});
		put(5'h00, 8'h20);
		chk(ctl, 8'h20);
		repeat (WAKE - 1) @(posedge ref_clk);
		#1;
		chk(ctl, 8'h20);
		@(posedge ref_clk);
		#1;
		chk(ctl, 8'h7C);
		$display("test standby done");
		put(5'h0D, 8'hC3);
		@(posedge ref_clk);
		#1 chip_enable = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1 chip_enable = 1'b1;
		for (int i = 0; i < 32; i++) shadow[i] = preset(5'(i));
		scan();
		$display("test activate pin done");
		end_of_test();
	end
endmodule
`default_nettype wire
